// >>> hdl/aasu_regs.svh
`ifndef AASU_REGS_SVH
`define AASU_REGS_SVH

// byte offsets on the register bus
`define AASU_CTRL_OFS      8'h00
`define AASU_ADDR_OFS      8'h04
`define AASU_CONST_OFS     8'h08
`define AASU_ACC_OFS       8'h0C
`define AASU_STATUS_OFS    8'h10
`define AASU_CMD_OFS       8'h14

// control field positions
`define AASU_CTRL_OP_LSB   0
`define AASU_CTRL_SRC_LSB  2
`define AASU_CTRL_RUNG_BIT 4
`define AASU_CMD_GO_BIT    0

// status field positions
`define AASU_ST_ZERO       0
`define AASU_ST_NEG        1
`define AASU_ST_BADPTR     2
`define AASU_ST_INVFLT     3
`define AASU_ST_SIGNERR    4
`define AASU_ST_UNDER      5
`define AASU_ST_OPTYPE     6
`define AASU_ST_BORROW16   7
`define AASU_ST_BORROW32   8
`define AASU_ST_BUSY       9

// reset values
`define AASU_CTRL_RST      5'h00
`define AASU_ADDR_RST      16'h0000
`define AASU_CONST_RST     32'h0000_0000
`define AASU_ACC_RST       32'h0000_0000

// word memory and real format
`define AASU_MEM_WORDS     17'h0_8000
`define AASU_QNAN          32'h7FC0_0000
`define AASU_EXP_ALL1      8'hFF

`endif

// >>> hdl/aasu_pkg.sv
package aasu_pkg;

  typedef enum logic [1:0] {
    aasu_real_add_op,
    aasu_bcd_subtract_op,
    aasu_bcd_subtract_double_op,
    aasu_real_subtract_op
  } aasu_op_e;

  typedef enum logic [1:0] {
    aasu_src_direct,
    aasu_src_pointer,
    aasu_src_const,
    aasu_src_spare
  } aasu_src_e;

  typedef enum logic [2:0] {
    aasu_idle,
    aasu_ptr_rd,
    aasu_ptr_chk,
    aasu_lo_rd,
    aasu_hi_rd,
    aasu_last,
    aasu_exec
  } aasu_state_e;

endpackage

// >>> hdl/aasu_top.sv
`timescale 1ns/1ps
`default_nettype none
`include "aasu_regs.svh"

module aasu_top
  import aasu_pkg::*;
(
  input  wire logic        core_clk,
  input  wire logic        resetn,
  input  wire logic [7:0]  s_axi_awaddr,
  input  wire logic        s_axi_awvalid,
  output logic             s_axi_awready,
  input  wire logic [31:0] s_axi_wdata,
  input  wire logic [3:0]  s_axi_wstrb,
  input  wire logic        s_axi_wvalid,
  output logic             s_axi_wready,
  output logic [1:0]       s_axi_bresp,
  output logic             s_axi_bvalid,
  input  wire logic        s_axi_bready,
  input  wire logic [7:0]  s_axi_araddr,
  input  wire logic        s_axi_arvalid,
  output logic             s_axi_arready,
  output logic [31:0]      s_axi_rdata,
  output logic [1:0]       s_axi_rresp,
  output logic             s_axi_rvalid,
  input  wire logic        s_axi_rready,
  output logic             mem_rd_en,
  output logic [15:0]      mem_addr,
  input  wire logic [15:0] mem_rdata
);
  import aasu_pkg::*;

  ////////////////////////////////////////////////////////////////////////////
  // bus slave
  logic [7:0]  aw_addr_reg;
  logic        aw_held_reg;
  logic [31:0] w_data_reg;
  logic [3:0]  w_strb_reg;
  logic        w_held_reg;
  logic [4:0]  ctrl_reg;
  logic [15:0] addr_reg;
  logic [31:0] const_reg;
  logic [31:0] acc_reg;
  logic [8:0]  flags_reg;
  logic        busy_reg;
  aasu_state_e state_reg;

  wire aw_fire = s_axi_awvalid && s_axi_awready;
  wire w_fire  = s_axi_wvalid && s_axi_wready;
  wire wr_do   = aw_held_reg && w_held_reg && !s_axi_bvalid;
  wire wr_ctrl  = wr_do && aw_addr_reg == `AASU_CTRL_OFS;
  wire wr_addr  = wr_do && aw_addr_reg == `AASU_ADDR_OFS;
  wire wr_const = wr_do && aw_addr_reg == `AASU_CONST_OFS;
  wire wr_acc   = wr_do && aw_addr_reg == `AASU_ACC_OFS;
  wire wr_cmd   = wr_do && aw_addr_reg == `AASU_CMD_OFS;
  wire wr_hit   = wr_ctrl || wr_addr || wr_const || wr_acc || wr_cmd
                  || (wr_do && aw_addr_reg == `AASU_STATUS_OFS);
  wire go       = wr_cmd && w_strb_reg[0] && w_data_reg[`AASU_CMD_GO_BIT] && !busy_reg;

  wire [31:0] wmask = {{8{w_strb_reg[3]}}, {8{w_strb_reg[2]}},
                       {8{w_strb_reg[1]}}, {8{w_strb_reg[0]}}};
  wire [31:0] status_word = {22'h00_0000, busy_reg, flags_reg};
  wire [4:0]  ctrl_wr_val = (ctrl_reg & ~wmask[4:0]) | (w_data_reg[4:0] & wmask[4:0]);

  wire        rd_hit = s_axi_araddr == `AASU_CTRL_OFS || s_axi_araddr == `AASU_ADDR_OFS
                    || s_axi_araddr == `AASU_CONST_OFS || s_axi_araddr == `AASU_ACC_OFS
                    || s_axi_araddr == `AASU_STATUS_OFS || s_axi_araddr == `AASU_CMD_OFS;
  wire [31:0] rd_mux =
    s_axi_araddr == `AASU_CTRL_OFS   ? {27'h000_0000, ctrl_reg} :
    s_axi_araddr == `AASU_ADDR_OFS   ? {16'h0000, addr_reg} :
    s_axi_araddr == `AASU_CONST_OFS  ? const_reg :
    s_axi_araddr == `AASU_ACC_OFS    ? acc_reg :
    s_axi_araddr == `AASU_STATUS_OFS ? status_word : 32'h0000_0000;

  always_ff @(posedge core_clk or negedge resetn) begin
    if (!resetn) begin
      s_axi_awready <= 1'b0;
      s_axi_wready  <= 1'b0;
      aw_held_reg   <= 1'b0;
      w_held_reg    <= 1'b0;
      aw_addr_reg   <= 8'h00;
      w_data_reg    <= 32'h0000_0000;
      w_strb_reg    <= 4'h0;
      s_axi_bvalid  <= 1'b0;
      s_axi_bresp   <= 2'b00;
    end else begin
      s_axi_awready <= !s_axi_awready && s_axi_awvalid && !aw_held_reg && !s_axi_bvalid;
      s_axi_wready  <= !s_axi_wready && s_axi_wvalid && !w_held_reg && !s_axi_bvalid;
      if (aw_fire) begin
        aw_held_reg <= 1'b1;
        aw_addr_reg <= {s_axi_awaddr[7:2], 2'b00};
      end
      if (w_fire) begin
        w_held_reg <= 1'b1;
        w_data_reg <= s_axi_wdata;
        w_strb_reg <= s_axi_wstrb;
      end
      if (wr_do) begin
        aw_held_reg  <= 1'b0;
        w_held_reg   <= 1'b0;
        s_axi_bvalid <= 1'b1;
        s_axi_bresp  <= wr_hit ? 2'b00 : 2'b11;
      end else if (s_axi_bvalid && s_axi_bready) begin
        s_axi_bvalid <= 1'b0;
      end
    end
  end

  always_ff @(posedge core_clk or negedge resetn) begin
    if (!resetn) begin
      s_axi_arready <= 1'b0;
      s_axi_rvalid  <= 1'b0;
      s_axi_rdata   <= 32'h0000_0000;
      s_axi_rresp   <= 2'b00;
    end else begin
      s_axi_arready <= !s_axi_arready && s_axi_arvalid && !s_axi_rvalid;
      if (s_axi_arvalid && s_axi_arready) begin
        s_axi_rvalid <= 1'b1;
        s_axi_rdata  <= rd_mux;
        s_axi_rresp  <= rd_hit ? 2'b00 : 2'b11;
      end else if (s_axi_rvalid && s_axi_rready) begin
        s_axi_rvalid <= 1'b0;
      end
    end
  end

  // setup registers are frozen while an operation runs
  always_ff @(posedge core_clk or negedge resetn) begin
    if (!resetn) begin
      ctrl_reg  <= `AASU_CTRL_RST;
      addr_reg  <= `AASU_ADDR_RST;
      const_reg <= `AASU_CONST_RST;
    end else if (!busy_reg) begin
      if (wr_ctrl)
        ctrl_reg <= ctrl_wr_val;
      if (wr_addr)
        addr_reg <= (addr_reg & ~wmask[15:0]) | (w_data_reg[15:0] & wmask[15:0]);
      if (wr_const)
        const_reg <= (const_reg & ~wmask) | (w_data_reg & wmask);
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // operand fetch
  aasu_op_e  op;
  aasu_src_e src;
  assign op  = aasu_op_e'(ctrl_reg[`AASU_CTRL_OP_LSB +: 2]);
  assign src = aasu_src_e'(ctrl_reg[`AASU_CTRL_SRC_LSB +: 2]);
  wire rung     = ctrl_reg[`AASU_CTRL_RUNG_BIT];
  wire op_short = op == aasu_bcd_subtract_op;
  wire op_real  = op == aasu_real_add_op || op == aasu_real_subtract_op;

  logic [15:0] op_lo_reg;
  logic [15:0] op_hi_reg;
  logic        bad_ptr_reg;
  logic        skip_reg;

  // a two-word operand must fit below the end of memory as well
  wire [16:0] ptr_end  = {1'b0, mem_rdata} + {16'h0000, !op_short};
  wire        ptr_bad  = ptr_end >= `AASU_MEM_WORDS;

  always_ff @(posedge core_clk or negedge resetn) begin
    if (!resetn) begin
      state_reg   <= aasu_idle;
      busy_reg    <= 1'b0;
      mem_rd_en   <= 1'b0;
      mem_addr    <= 16'h0000;
      op_lo_reg   <= 16'h0000;
      op_hi_reg   <= 16'h0000;
      bad_ptr_reg <= 1'b0;
      skip_reg    <= 1'b0;
    end else begin
      case (state_reg)
        aasu_idle: begin
          bad_ptr_reg <= 1'b0;
          if (go) begin
            busy_reg  <= 1'b1;
            skip_reg  <= !rung || src == aasu_src_spare;
            op_lo_reg <= const_reg[15:0];
            op_hi_reg <= const_reg[31:16];
            mem_addr  <= addr_reg;
            if (!rung || src == aasu_src_const || src == aasu_src_spare) begin
              state_reg <= aasu_exec;
            end else begin
              mem_rd_en <= 1'b1;
              state_reg <= src == aasu_src_pointer ? aasu_ptr_rd : aasu_lo_rd;
            end
          end
        end
        aasu_ptr_rd: begin
          mem_rd_en <= 1'b0;
          state_reg <= aasu_ptr_chk;
        end
        aasu_ptr_chk: begin
          if (ptr_bad) begin
            bad_ptr_reg <= 1'b1;
            state_reg   <= aasu_exec;
          end else begin
            mem_rd_en <= 1'b1;
            mem_addr  <= mem_rdata;
            state_reg <= aasu_lo_rd;
          end
        end
        aasu_lo_rd: begin
          mem_rd_en <= !op_short;
          mem_addr  <= op_short ? mem_addr : mem_addr + 16'h0001;
          state_reg <= op_short ? aasu_last : aasu_hi_rd;
        end
        aasu_hi_rd: begin
          mem_rd_en <= 1'b0;
          op_lo_reg <= mem_rdata;
          state_reg <= aasu_last;
        end
        aasu_last: begin
          if (op_short)
            op_lo_reg <= mem_rdata;
          else
            op_hi_reg <= mem_rdata;
          state_reg <= aasu_exec;
        end
        aasu_exec: begin
          busy_reg  <= 1'b0;
          state_reg <= aasu_idle;
        end
        default: state_reg <= aasu_idle;
      endcase
    end
  end

  wire [31:0] operand = op_short ? {16'h0000, op_lo_reg} : {op_hi_reg, op_lo_reg};

  ////////////////////////////////////////////////////////////////////////////
  // BCD subtract, one digit per stage
  wire [31:0] bcd_a = op_short ? {16'h0000, acc_reg[15:0]} : acc_reg;
  logic [8:0]  bcd_br;
  logic [31:0] bcd_res;
  logic [7:0]  bcd_bad;
  assign bcd_br[0] = 1'b0;

  genvar g;
  generate
    for (g = 0; g < 8; g++) begin : g_digit
      wire [4:0] t = {1'b0, bcd_a[4*g +: 4]} - {1'b0, operand[4*g +: 4]}
                     - {4'h0, bcd_br[g]};
      wire [4:0] f = t + 5'h0A;
      assign bcd_res[4*g +: 4] = t[4] ? f[3:0] : t[3:0];
      assign bcd_br[g+1]       = t[4];
      assign bcd_bad[g] = operand[4*g +: 4] > 4'h9 || bcd_a[4*g +: 4] > 4'h9;
    end
  endgenerate

  wire bcd_nonbcd = op_short ? |bcd_bad[3:0] : |bcd_bad;

  ////////////////////////////////////////////////////////////////////////////
  // real add / subtract, truncating, denormals flushed to zero
  logic [31:0] fp_res;
  logic        fp_optype;
  logic        fp_invalid;
  logic        fp_under;
  logic        fp_signerr;

  always_comb begin
    logic [7:0]  ea;
    logic [7:0]  eb;
    logic        sa;
    logic        sb;
    logic        a_big;
    logic [7:0]  eh;
    logic [7:0]  d;
    logic [26:0] mh;
    logic [26:0] ml;
    logic [27:0] sum;
    logic [4:0]  lead;
    logic [26:0] norm;
    logic [9:0]  ex;
    logic        sr;
    norm = 27'h000_0000;
    ex   = 10'h000;
    ea = acc_reg[30:23];
    eb = operand[30:23];
    sa = acc_reg[31];
    sb = operand[31] ^ (op == aasu_real_subtract_op);
    a_big = acc_reg[30:0] >= operand[30:0];
    eh = a_big ? ea : eb;
    d  = a_big ? ea - eb : eb - ea;
    mh = a_big ? {ea != 8'h00, acc_reg[22:0], 3'b000} : {eb != 8'h00, operand[22:0], 3'b000};
    ml = a_big ? {eb != 8'h00, operand[22:0], 3'b000} : {ea != 8'h00, acc_reg[22:0], 3'b000};
    // small operand shifted past every guard bit drops out entirely
    ml = d > 8'd26 ? 27'h000_0000 : ml >> d;
    sr = a_big ? sa : sb;
    sum = sa == sb ? {1'b0, mh} + {1'b0, ml} : {1'b0, mh} - {1'b0, ml};
    lead = 5'd0;
    for (int i = 0; i < 28; i++) begin
      if (sum[i])
        lead = 5'(i);
    end
    if (sum[27]) begin
      norm = sum[27:1];
      ex   = {2'b00, eh} + 10'd1;
    end else begin
      norm = sum[26:0] << (5'd26 - lead);
      ex   = {2'b00, eh} - {5'b00000, 5'd26 - lead};
    end
    fp_optype  = ea == `AASU_EXP_ALL1 || eb == `AASU_EXP_ALL1;
    fp_invalid = 1'b0;
    fp_under   = 1'b0;
    fp_signerr = 1'b0;
    if (fp_optype) begin
      fp_res     = `AASU_QNAN;
      fp_invalid = 1'b1;
    end else if (sum == 28'h000_0000 || mh[26] == 1'b0) begin
      fp_res = {sr & mh[26], 31'h0000_0000};
    end else if (ex[9] || ex == 10'd0) begin
      fp_res   = 32'h0000_0000;
      fp_under = 1'b1;
    end else if (ex >= 10'd255) begin
      // sign can no longer be trusted once the magnitude overflows
      fp_res     = {sr, `AASU_EXP_ALL1, 23'h00_0000};
      fp_invalid = 1'b1;
      fp_signerr = 1'b1;
    end else begin
      fp_res = {sr, ex[7:0], norm[25:3]};
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // accumulator and flags
  // a constant for the short BCD subtract is refused as a bad operand
  wire        short_const = op_short && src == aasu_src_const;
  wire        op_err  = op_real ? fp_optype : (bcd_nonbcd || short_const);
  wire [31:0] result  = op_real ? fp_res : (op_short ? {16'h0000, bcd_res[15:0]} : bcd_res);
  wire        res_upd = !bad_ptr_reg && (op_real || !op_err);
  wire [31:0] acc_new = res_upd ? result : acc_reg;
  wire        exec_run = state_reg == aasu_exec && !skip_reg;
  wire        zero_new = op_real ? acc_new[30:0] == 31'h0000_0000 : acc_new == 32'h0000_0000;
  wire        neg_new  = acc_new[31] && !zero_new;

  logic [8:0] flags_next;
  always_comb begin
    flags_next = flags_reg;
    flags_next[`AASU_ST_ZERO]   = zero_new;
    flags_next[`AASU_ST_NEG]    = neg_new;
    flags_next[`AASU_ST_BADPTR] = bad_ptr_reg;
    flags_next[`AASU_ST_OPTYPE] = !bad_ptr_reg && op_err;
    if (op_real) begin
      flags_next[`AASU_ST_INVFLT]  = !bad_ptr_reg && fp_invalid;
      flags_next[`AASU_ST_SIGNERR] = !bad_ptr_reg && fp_signerr;
      flags_next[`AASU_ST_UNDER]   = !bad_ptr_reg && fp_under;
    end else if (op_short) begin
      flags_next[`AASU_ST_BORROW16] = res_upd && bcd_br[4];
    end else begin
      flags_next[`AASU_ST_BORROW32] = res_upd && bcd_br[8];
    end
  end

  always_ff @(posedge core_clk or negedge resetn) begin
    if (!resetn) begin
      acc_reg   <= `AASU_ACC_RST;
      flags_reg <= 9'h000;
    end else if (exec_run) begin
      acc_reg   <= acc_new;
      flags_reg <= flags_next;
    end else if (wr_acc && !busy_reg) begin
      acc_reg <= (acc_reg & ~wmask) | (w_data_reg & wmask);
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // checks
  norun_hold_a: assert property (@(posedge core_clk) disable iff (!resetn)
    state_reg == aasu_exec && skip_reg |=> $stable(acc_reg) && $stable(flags_reg))
    else $error("skipped operation changed state");
  short_upper_a: assert property (@(posedge core_clk) disable iff (!resetn)
    exec_run && op_short && res_upd |=> acc_reg[31:16] == 16'h0000)
    else $error("short bcd result upper half not zero");
  zero_flag_a: assert property (@(posedge core_clk) disable iff (!resetn)
    exec_run && !op_real |=> flags_reg[`AASU_ST_ZERO] == (acc_reg == 32'h0000_0000))
    else $error("zero flag disagrees with accumulator");
  neg_flag_a: assert property (@(posedge core_clk) disable iff (!resetn)
    exec_run |=> flags_reg[`AASU_ST_NEG] == (acc_reg[31] && !flags_reg[`AASU_ST_ZERO]))
    else $error("negative flag disagrees with accumulator");
  short_const_a: assert property (@(posedge core_clk) disable iff (!resetn)
    exec_run && short_const |=> flags_reg[`AASU_ST_OPTYPE] && $stable(acc_reg))
    else $error("constant accepted for short bcd subtract");
  bad_ptr_a: assert property (@(posedge core_clk) disable iff (!resetn)
    state_reg == aasu_ptr_chk && ptr_bad && !skip_reg
    |=> ##1 flags_reg[`AASU_ST_BADPTR] && $stable(acc_reg))
    else $error("invalid pointer not flagged");
  inv_float_a: assert property (@(posedge core_clk) disable iff (!resetn)
    exec_run && op_real && !bad_ptr_reg
    |=> flags_reg[`AASU_ST_INVFLT] == (acc_reg[30:23] == `AASU_EXP_ALL1))
    else $error("invalid float flag disagrees with accumulator");
  under_zero_a: assert property (@(posedge core_clk) disable iff (!resetn)
    exec_run && op_real && fp_under |=> acc_reg == 32'h0000_0000)
    else $error("underflow left nonzero accumulator");
  busy_bound_a: assert property (@(posedge core_clk) disable iff (!resetn)
    go |=> busy_reg ##[1:7] !busy_reg)
    else $error("operation did not finish in time");
  borrow32_a: assert property (@(posedge core_clk) disable iff (!resetn)
    exec_run && op == aasu_bcd_subtract_double_op && !op_err && !bad_ptr_reg
    && acc_reg < operand |=> flags_reg[`AASU_ST_BORROW32])
    else $error("double bcd borrow missing");

  real_add_c: cover property (@(posedge core_clk) disable iff (!resetn)
    exec_run && op == aasu_real_add_op && src == aasu_src_pointer);
  bcd_borrow_c: cover property (@(posedge core_clk) disable iff (!resetn)
    exec_run && op == aasu_bcd_subtract_double_op && bcd_br[8]);
  bad_ptr_c: cover property (@(posedge core_clk) disable iff (!resetn)
    state_reg == aasu_ptr_chk && ptr_bad);
  real_sub_under_c: cover property (@(posedge core_clk) disable iff (!resetn)
    exec_run && op == aasu_real_subtract_op && fp_under);

endmodule

`default_nettype wire

// >>> tb/aasu_mem_model.sv
`timescale 1ns/1ps
`default_nettype none
module aasu_mem_model (
  input  wire logic        core_clk,
  input  wire logic        mem_rd_en,
  input  wire logic [15:0] mem_addr,
  output logic [15:0]      mem_rdata
);
  logic [15:0] words [0:32767];
  // outside a read the bus flips every cycle so a stale word never passes
  always @(posedge core_clk) begin
    if (mem_rd_en) begin
      mem_rdata <= words[mem_addr[14:0]];
    end else begin
      mem_rdata <= ~mem_rdata;
    end
  end
endmodule
`default_nettype wire

// >>> tb/accumulator_add_sub_unit_test.sv
`timescale 1ns/1ps
`default_nettype none
`include "aasu_regs.svh"
module accumulator_add_sub_unit_test;
  import aasu_pkg::*;
  typedef struct packed {
    logic [4:0]  ctrl;
    logic [15:0] addr;
    logic [31:0] cnst;
    logic [31:0] acc;
    logic [31:0] eacc;
    logic [31:0] est;
  } aasu_row_s;
  logic        core_clk = 1'b0;
  logic        resetn = 1'b0;
  logic [7:0]  awaddr = 8'h00;
  logic [7:0]  araddr = 8'h00;
  logic [31:0] wdata = 32'h0000_0000;
  logic        awvalid = 1'b0;
  logic        wvalid = 1'b0;
  logic        bready = 1'b0;
  logic        arvalid = 1'b0;
  logic        rready = 1'b0;
  wire         awready, wready, bvalid, arready, rvalid, mem_rd_en;
  wire  [1:0]  bresp, rresp;
  wire  [31:0] rdata;
  wire  [15:0] mem_addr, mem_rdata;
  int          num_errors = 0;
  int          tests_run = 0;
  logic [31:0] rd;
  logic [1:0]  rs;
  aasu_row_s   rows [0:18];
  aasu_top DUT (.core_clk(core_clk), .resetn(resetn), .s_axi_awaddr(awaddr),
    .s_axi_awvalid(awvalid), .s_axi_awready(awready), .s_axi_wdata(wdata),
    .s_axi_wstrb(4'hF), .s_axi_wvalid(wvalid), .s_axi_wready(wready),
    .s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(bready),
    .s_axi_araddr(araddr), .s_axi_arvalid(arvalid), .s_axi_arready(arready),
    .s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid),
    .s_axi_rready(rready), .mem_rd_en(mem_rd_en), .mem_addr(mem_addr),
    .mem_rdata(mem_rdata));
  aasu_mem_model mem (.core_clk(core_clk), .mem_rd_en(mem_rd_en), .mem_addr(mem_addr),
    .mem_rdata(mem_rdata));
  always #4 core_clk = ~core_clk;
  ////////////////////////////////////////////////////////////////////////////
  task automatic close_out();
    $display("comparisons %0d mismatches %0d", tests_run, num_errors);
    if (num_errors == 0 && tests_run > 0) begin
      $display("No errors found");
    end else begin
      $display("Errors were found");
    end
    $finish;
  endtask
  task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
    tests_run++;
    if (got !== exp) begin
      num_errors++;
      $display("unexpected %s: expected %h seen %h", what, exp, got);
    end
  endtask
  task automatic tick(inout int n);
    @(posedge core_clk);
    n++;
    if (n > 60) begin
      num_errors++;
      close_out();
    end
  endtask
  // bready rides with the request; the slave may answer on any of the next 60 edges
  task automatic axi_wr(input logic [7:0] a, input logic [31:0] d, output logic [1:0] r);
    int n;
    n = 0;
    @(posedge core_clk);
    awaddr <= a;
    wdata <= d;
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    bready <= 1'b1;
    do begin
      tick(n);
      if (awready) awvalid <= 1'b0;
      if (wready) wvalid <= 1'b0;
    end while (bvalid !== 1'b1);
    r = bresp;
    bready <= 1'b0;
  endtask
  task automatic axi_rd(input logic [7:0] a, output logic [31:0] d, output logic [1:0] r);
    int n;
    n = 0;
    @(posedge core_clk);
    araddr <= a;
    arvalid <= 1'b1;
    rready <= 1'b1;
    do begin
      tick(n);
      if (arready) arvalid <= 1'b0;
    end while (rvalid !== 1'b1);
    d = rdata;
    r = rresp;
    rready <= 1'b0;
  endtask
  task automatic run_op(input aasu_row_s r);
    int n;
    axi_wr(`AASU_ACC_OFS, r.acc, rs);
    axi_wr(`AASU_CONST_OFS, r.cnst, rs);
    axi_wr(`AASU_ADDR_OFS, {16'h0000, r.addr}, rs);
    axi_wr(`AASU_CTRL_OFS, {27'h000_0000, r.ctrl}, rs);
    axi_wr(`AASU_CMD_OFS, 32'h0000_0001, rs);
    n = 0;
    do begin
      axi_rd(`AASU_STATUS_OFS, rd, rs);
      tick(n);
    end while (rd[`AASU_ST_BUSY] !== 1'b0);
    chk("status", r.est, rd);
    axi_rd(`AASU_ACC_OFS, rd, rs);
    chk("accumulator", r.eacc, rd);
  endtask
  ////////////////////////////////////////////////////////////////////////////
  initial begin
    // ctrl = rung, src, op
    rows[0] = '{5'h18, 16'h0000, 32'h4170_0000, 32'h40E0_0000, 32'h41B0_0000, 32'h000};
    rows[1] = '{5'h10, 16'h0100, 32'h0000_0000, 32'h40E0_0000, 32'h41B0_0000, 32'h000};
    rows[2] = '{5'h1B, 16'h0000, 32'h4170_0000, 32'h40E0_0000, 32'hC100_0000, 32'h002};
    rows[3] = '{5'h1B, 16'h0000, 32'h4170_0000, 32'h4170_0000, 32'h0000_0000, 32'h001};
    rows[4] = '{5'h18, 16'h0000, 32'h3F80_0000, 32'h4B80_0000, 32'h4B80_0000, 32'h000};
    rows[5] = '{5'h11, 16'h0110, 32'h0000_0000, 32'h0000_0050, 32'h0000_0030, 32'h000};
    rows[6] = '{5'h11, 16'h0111, 32'h0000_0000, 32'h0000_0020, 32'h0000_9970, 32'h080};
    rows[7] = '{5'h19, 16'h0000, 32'h0000_0020, 32'h0000_0050, 32'h0000_0050, 32'h040};
    rows[8] = '{5'h1A, 16'h0000, 32'h0002_3456, 32'h0012_3456, 32'h0010_0000, 32'h000};
    rows[9] = '{5'h12, 16'h0120, 32'h0000_0000, 32'h0000_0001, 32'h9999_9999, 32'h102};
    rows[10] = '{5'h1A, 16'h0000, 32'h0000_000A, 32'h0000_0005, 32'h0000_0005, 32'h040};
    rows[11] = '{5'h18, 16'h0000, 32'h7F80_0000, 32'h40E0_0000, 32'h7FC0_0000, 32'h048};
    // invalid float from the row before is not owned by a bcd subtract, so it stays
    rows[12] = '{5'h15, 16'h0200, 32'h0000_0000, 32'h0000_0033, 32'h0000_0022, 32'h008};
    rows[13] = '{5'h14, 16'h0210, 32'h0000_0000, 32'h40E0_0000, 32'h40E0_0000, 32'h004};
    rows[14] = '{5'h08, 16'h0000, 32'h4170_0000, 32'h40E0_0000, 32'h40E0_0000, 32'h004};
    rows[15] = '{5'h1B, 16'h0000, 32'h0080_0000, 32'h00C0_0000, 32'h0000_0000, 32'h021};
    rows[16] = '{5'h18, 16'h0000, 32'h7F7F_FFFF, 32'h7F7F_FFFF, 32'h7F80_0000, 32'h018};
    rows[17] = '{5'h1C, 16'h0000, 32'h4170_0000, 32'h1234_5678, 32'h1234_5678, 32'h018};
    rows[18] = '{5'h17, 16'h0220, 32'h0000_0000, 32'h41B0_0000, 32'h40E0_0000, 32'h000};
    mem.words[16'h0100] = 16'h0000;
    mem.words[16'h0101] = 16'h4170;
    mem.words[16'h0110] = 16'h0020;
    mem.words[16'h0111] = 16'h0050;
    mem.words[16'h0120] = 16'h0002;
    mem.words[16'h0121] = 16'h0000;
    mem.words[16'h0200] = 16'h0300;
    mem.words[16'h0300] = 16'h0011;
    mem.words[16'h0210] = 16'h8000;
    mem.words[16'h0220] = 16'h0100;
    repeat (20) @(posedge core_clk);
    resetn <= 1'b1;
    foreach (rows[i]) run_op(rows[i]);
    // second reset in mid-run clears everything
    @(posedge core_clk);
    resetn <= 1'b0;
    repeat (20) @(posedge core_clk);
    resetn <= 1'b1;
    axi_rd(`AASU_ACC_OFS, rd, rs);
    chk("acc after reset", 32'h0000_0000, rd);
    axi_rd(`AASU_STATUS_OFS, rd, rs);
    chk("status after reset", 32'h0000_0000, rd);
    axi_rd(`AASU_CTRL_OFS, rd, rs);
    chk("ctrl after reset", 32'h0000_0000, rd);
    axi_wr(`AASU_STATUS_OFS, 32'h0000_01FF, rs);
    axi_rd(`AASU_STATUS_OFS, rd, rs);
    chk("status read only", 32'h0000_0000, rd);
    axi_rd(8'h18, rd, rs);
    chk("unmapped rresp", 32'h0000_0003, {30'h0, rs});
    axi_wr(8'h1C, 32'h1234_5678, rs);
    chk("unmapped bresp", 32'h0000_0003, {30'h0, rs});
    close_out();
  end
endmodule
`default_nettype wire
